// >>> src/mcs_pkg.sv
// Shared constants and types for the modulator clock synchroniser.
package mcs_pkg;
    // Core clock period in picoseconds (250 MHz).
    localparam int unsigned MCS_CLK_PS        = 4000;
    // Accepted sync input band, in kHz.
    localparam int unsigned MCS_SYNC_MIN_KHZ  = 5000;
    localparam int unsigned MCS_SYNC_MAX_KHZ  = 12000;
    // Preferred band for the source, kept for reference only; the bench does not use it.
    localparam int unsigned MCS_SYNC_OPT_LO_KHZ = 6000;
    localparam int unsigned MCS_SYNC_OPT_HI_KHZ = 9000;
    // Longest sync period in core cycles at the slowest accepted rate.
    localparam int unsigned MCS_SLOW_PER_CYC  = (1000000000 / MCS_SYNC_MIN_KHZ) / MCS_CLK_PS;
    // Clock-loss threshold: twice the slowest period without an edge.
    localparam int unsigned MCS_LOSS_CYC      = 2 * MCS_SLOW_PER_CYC;
    // Training length in internal clock periods; forwarding delay in core clock cycles.
    localparam int unsigned MCS_TRAIN_CYC     = 127;
    localparam int unsigned MCS_DLY_DEPTH     = 127;
    // Internal periods shown on the sync output before locking to a newly seen source.
    localparam int unsigned MCS_LOCK_OSC      = 4;
    // Internal oscillator half period in core cycles (about 6.25 MHz).
    localparam int unsigned MCS_OSC_HALF      = 20;
    localparam int unsigned MCS_CNT_W         = 8;

    typedef enum logic [4:0] {
        MCS_OFF   = 5'h01,
        MCS_REF   = 5'h02,
        MCS_TRAIN = 5'h04,
        MCS_INT   = 5'h08,
        MCS_EXT   = 5'h10
    } mcs_state_t;
endpackage

// >>> src/mcs_delay_line.sv
// Shift-register delay line for the forwarded sync clock.
`timescale 1ns/1ns
module mcs_delay_line #(
    parameter int unsigned DEPTH = 127
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Data
    input  wire logic i_en,
    input  wire logic i_d,
    output logic      o_q
);
    logic [DEPTH-1:0] line_r;
    logic [DEPTH-1:0] line_nxt;

    always_comb begin
        line_nxt = line_r;
        if (i_en) begin
            line_nxt = {line_r[DEPTH-2:0], i_d};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            line_r <= '0;
        end else begin
            line_r <= line_nxt;
        end
    end

    assign o_q = line_r[DEPTH-1];
endmodule

// >>> src/mcs_sync_core.sv
// Clock selection, training and sync forwarding for the modulator.
`timescale 1ns/1ns
// What this block does
// - Standalone, master (loopback) and slave roles are all supported.
// - Accept a 5 to 12 MHz sync input clock and run the modulator on it.
// - No synchronisation happens until shutdown is released.
// - Master (loopback) sync output is the internal clock delayed by 128 core cycles (127-stage line plus output register).
// - Startup marker releases after one full internal clock cycle.
// - Switching release held for 127 internal cycles of training after the marker.
// - Sync output carries the internal clock during training.
// - Static sync input: sync output quiet, modulator on internal clock.
// - Looped-back sync input: sync output is the delayed internal clock.
// - External clock on sync input: sync output buffers it.
// - One irregular modulator pulse may occur when switching to external clock.
// - From static to clock: several internal cycles first, then lock.
// - From clock to static: buffered sync output stops at once; a master's delayed clock runs on until the loss-detect interval ends.
// - After a loss-detect interval the modulator returns to the internal clock.
module mcs_sync_core
    import mcs_pkg::*;
#(
    parameter int unsigned LOSS_CYC  = mcs_pkg::MCS_LOSS_CYC,
    parameter int unsigned OSC_HALF  = mcs_pkg::MCS_OSC_HALF,
    parameter int unsigned TRAIN_CYC = mcs_pkg::MCS_TRAIN_CYC,
    parameter int unsigned DLY_DEPTH = mcs_pkg::MCS_DLY_DEPTH
) (
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_sys_rst,
    // Control pin
    input  wire logic                i_shutdown_n,
    // Sync pins
    input  wire logic                i_sync_in,
    output logic                     o_sync_out,
    // Modulator side
    output logic                     o_mod_clk,
    output logic                     o_switching_release,
    output logic                     o_ext_mode,
    output mcs_pkg::mcs_state_t      o_state
);
    import mcs_pkg::*;

    localparam int unsigned LW = $clog2(LOSS_CYC + 1);

    // Sync input synchroniser; stages two and three are looked at.
    logic       sin_s1_r;
    logic       sin_s2_r;
    logic       sin_s3_r;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
            sin_s3_r <= 1'b0;
        end else begin
            sin_s1_r <= i_sync_in;
            sin_s2_r <= sin_s1_r;
            sin_s3_r <= sin_s2_r;
        end
    end
    logic sin_rise;
    assign sin_rise = sin_s2_r & ~sin_s3_r;

    // Internal oscillator derived from the core clock; half-period enable divider.
    logic [MCS_CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
    logic                 osc_r, osc_nxt;
    logic                 osc_tick;
    assign osc_tick = (osc_cnt_r == MCS_CNT_W'(OSC_HALF - 1));
    always_comb begin
        osc_cnt_nxt = osc_tick ? '0 : osc_cnt_r + 1'b1;
        osc_nxt     = osc_tick ? ~osc_r : osc_r;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_shutdown_n) begin
            osc_cnt_r <= '0;
            osc_r     <= 1'b0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_r     <= osc_nxt;
        end
    end
    logic osc_rise;
    assign osc_rise = osc_tick & ~osc_r;

    // Edge-loss counter: saturates when the input has had no rising edge.
    logic [LW-1:0] idle_r, idle_nxt;
    logic          in_live;
    always_comb begin
        if (sin_rise) begin
            idle_nxt = '0;
        end else if (idle_r != LW'(LOSS_CYC)) begin
            idle_nxt = idle_r + 1'b1;
        end else begin
            idle_nxt = idle_r;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            idle_r <= LW'(LOSS_CYC);
        end else begin
            idle_r <= idle_nxt;
        end
    end
    assign in_live = (idle_r != LW'(LOSS_CYC));

    // Mode sequencer.
    mcs_state_t    st_r, st_nxt;
    logic [7:0]    tr_r, tr_nxt;
    logic          loop_r, loop_nxt;
    logic [1:0]    so_h_r, so_h_nxt;
    always_comb begin
        st_nxt   = st_r;
        tr_nxt   = tr_r;
        loop_nxt = loop_r;
        case (st_r)
            MCS_OFF: begin
                if (i_shutdown_n) begin
                    st_nxt = MCS_REF;
                end
            end
            MCS_REF: begin
                // One whole oscillator period, ending on its second rising edge.
                loop_nxt = 1'b1;
                if (osc_rise) begin
                    tr_nxt = tr_r + 1'b1;
                    if (tr_r == 8'h01) begin
                        st_nxt = MCS_TRAIN;
                        tr_nxt = 8'h00;
                    end
                end
            end
            MCS_TRAIN: begin
                // A looped-back pin echoes our own output two register stages late.
                // Any other difference means a foreign source or a static level.
                if (sin_s2_r != so_h_r[1]) begin
                    loop_nxt = 1'b0;
                end
                if (osc_rise) begin
                    tr_nxt = tr_r + 1'b1;
                    if (tr_r == 8'(TRAIN_CYC - 1)) begin
                        st_nxt = in_live ? MCS_EXT : MCS_INT;
                        tr_nxt = 8'h00;
                    end
                end
            end
            MCS_INT: begin
                if (!in_live) begin
                    tr_nxt = 8'h00;
                end else if (osc_rise) begin
                    tr_nxt = tr_r + 1'b1;
                    if (tr_r == 8'(MCS_LOCK_OSC - 1)) begin
                        st_nxt = MCS_EXT;
                        tr_nxt = 8'h00;
                    end
                end
            end
            MCS_EXT: begin
                if (!in_live) begin
                    st_nxt   = MCS_INT;
                    loop_nxt = 1'b0;
                end
            end
            default: st_nxt = MCS_OFF;
        endcase
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_shutdown_n) begin
            st_r   <= MCS_OFF;
            tr_r   <= 8'h00;
            loop_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tr_r   <= tr_nxt;
            loop_r <= loop_nxt;
        end
    end

    // The delay line always carries the internal clock; a master feeds its own pin from it.
    // Its long lag also staggers the edges of chained parts.
    logic dly_in;
    logic dly_q;
    assign dly_in = osc_r;
    mcs_delay_line #(
        .DEPTH (DLY_DEPTH)
    ) u_dly (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_en       (1'b1),
        .i_d        (dly_in),
        .o_q        (dly_q)
    );

    // Outputs registered. Static input in INT mode silences the pin at once.
    logic so_r, so_nxt, mc_r, mc_nxt;
    always_comb begin
        so_nxt   = 1'b0;
        so_h_nxt = {so_h_r[0], so_r};
        if (st_r == MCS_TRAIN || st_r == MCS_REF) begin
            so_nxt = osc_r;
        end else if (st_r == MCS_EXT && loop_r) begin
            // A master has no other source, so a broken loop ends its clock as well.
            so_nxt = dly_q;
        end else if (st_r == MCS_EXT) begin
            so_nxt = sin_s2_r;
        end else if (st_r == MCS_INT && in_live) begin
            so_nxt = osc_r;
        end
        // Switching to the external clock may cut a modulator phase short.
        mc_nxt = (st_r == MCS_EXT) ? sin_s2_r : osc_r;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_shutdown_n) begin
            so_r   <= 1'b0;
            mc_r   <= 1'b0;
            so_h_r <= 2'h0;
        end else begin
            so_r   <= so_nxt;
            mc_r   <= mc_nxt;
            so_h_r <= so_h_nxt;
        end
    end

    assign o_sync_out          = so_r;
    assign o_mod_clk           = mc_r;
    assign o_switching_release = (st_r == MCS_INT) || (st_r == MCS_EXT);
    assign o_ext_mode          = (st_r == MCS_EXT);
    assign o_state             = st_r;

    // Checks.
    sequence train_done_s;
        (st_r == MCS_TRAIN) && osc_rise && (tr_r == 8'(TRAIN_CYC - 1));
    endsequence
    train_exit_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        train_done_s |=> o_switching_release) else $error("training did not release");
    hold_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_shutdown_n |=> (st_r == MCS_OFF) && !o_sync_out) else $error("active in shutdown");
    quiet_static_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        (st_r == MCS_INT) && !in_live |=> !o_sync_out) else $error("sync out toggles when static");
    loss_back_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        (st_r == MCS_EXT) && !in_live |=> (st_r == MCS_INT)) else $error("no fallback on loss");
    release_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        (st_r == MCS_TRAIN) |-> !o_switching_release) else $error("release during training");
    train_out_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        (st_r == MCS_TRAIN) && $past(st_r == MCS_TRAIN) |-> o_sync_out == $past(osc_r)) else $error("train out");
    mod_int_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        (st_r == MCS_INT) ##1 (st_r == MCS_INT) |-> o_mod_clk == $past(osc_r)) else $error("mod not internal");
    ref_len_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !i_shutdown_n)
        $rose(st_r == MCS_REF) |-> (st_r == MCS_REF) [*8]) else $error("marker too early");
endmodule

// >>> sim/mcs_partner.sv
// Model of the clock source or neighbour that drives the sync input.
`timescale 1ns/1ns
module mcs_partner #(
    parameter int unsigned HALF = 16
) (
    // Clock and mode
    input  wire logic       i_core_clk,
    input  wire logic [1:0] i_mode,
    // Sync pins
    input  wire logic       i_sync_out,
    output logic            o_sync_in
);
    int unsigned cnt_r = 0;
    logic        clk_r = 1'b0;
    initial o_sync_in = 1'b0;
    // A half period of 16 core cycles gives 7.8 MHz, well inside the band the device accepts.
    always @(negedge i_core_clk) begin
        cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
        if (cnt_r == HALF - 1) begin
            clk_r <= ~clk_r;
        end
        case (i_mode)
            2'h0: o_sync_in <= 1'b0;
            2'h1: o_sync_in <= 1'b1;
            2'h2: o_sync_in <= clk_r;
            default: o_sync_in <= i_sync_out;
        endcase
    end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the modulator clock synchroniser.
`timescale 1ns/1ns
module tb_top;
    import mcs_pkg::*;
    localparam int unsigned TRAIN = 4;
    localparam int unsigned LOSS  = 100;
    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic       sd_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic       sync_in;
    logic       sync_out;
    logic       mod_clk;
    logic       rel;
    logic       ext;
    mcs_state_t state;
    int         fails = 0;
    int         comparisons = 0;
    int         ts;
    int         tm;
    int         n;
    initial forever #2 clk = ~clk;
    mcs_sync_core #(.LOSS_CYC(LOSS), .TRAIN_CYC(TRAIN)) i_mcs_sync_core (
        .i_core_clk(clk), .i_sys_rst(rst), .i_shutdown_n(sd_n), .i_sync_in(sync_in),
        .o_sync_out(sync_out), .o_mod_clk(mod_clk), .o_switching_release(rel),
        .o_ext_mode(ext), .o_state(state));
    mcs_partner i_mcs_partner (.i_core_clk(clk), .i_mode(mode), .i_sync_out(sync_out), .o_sync_in(sync_in));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Toggles of the sync output and modulator clock over c cycles.
    task automatic watch(input int c);
        logic ps;
        logic pm;
        ts = 0;
        tm = 0;
        repeat (c) begin
            ps = sync_out;
            pm = mod_clk;
            tick(1);
            ts += int'(sync_out !== ps);
            tm += int'(mod_clk !== pm);
        end
    endtask
    task automatic wait_st(input mcs_state_t s, input int lim);
        n = 0;
        while (state !== s && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    // Shutdown held with a live clock on the sync input: nothing may move.
    task automatic t_shut();
        mode = 2'h2;
        sd_n = 1'b0;
        watch(200);
        chk("state_off", state, MCS_OFF);
        chk("sync_quiet", ts, 0);
        chk("release_off", rel, 1'b0);
    endtask
    // Restart from shutdown, then time the training interval.
    task automatic start(input logic [1:0] m);
        mode = m;
        sd_n = 1'b0;
        tick(4);
        sd_n = 1'b1;
        tick(1);
        chk("state_ref", state, MCS_REF);
        wait_st(MCS_TRAIN, 200);
        chk("release_low", rel, 1'b0);
        wait_st(MCS_INT, 1000);
        // One training step is a full internal clock period of two half periods.
        chk("train_len", 16'(n), 16'(TRAIN * 2 * MCS_OSC_HALF));
        chk("release_high", rel, 1'b1);
    endtask
    task automatic t_static();
        for (int l = 0; l < 2; l++) begin
            start(2'(l));
            chk("ext_off", ext, 1'b0);
            watch(300);
            chk("sync_stop", ts, 0);
            chk("mod_runs", tm > 0, 1'b1);
        end
    endtask
    task automatic t_ext();
        start(2'h0);
        mode = 2'h2;
        watch(70);
        chk("lock_wait", state, MCS_INT);
        chk("pre_lock_osc", ts > 0, 1'b1);
        wait_st(MCS_EXT, int'(MCS_LOCK_OSC * 2 * MCS_OSC_HALF) + 40);
        chk("ext_lock", ext, 1'b1);
        tick(32);
        watch(256);
        // The source toggles every 16 cycles, so 256 cycles hold 16 edges.
        chk("sync_follow", ts >= 15 && ts <= 17, 1'b1);
        chk("mod_follow", tm > 0, 1'b1);
        mode = 2'h0;
        tick(6);
        watch(40);
        chk("sync_halt", ts, 0);
        wait_st(MCS_INT, LOSS + 60);
        chk("back_int", state, MCS_INT);
        chk("ext_drop", ext, 1'b0);
    endtask
    task automatic t_loop();
        mode = 2'h3;
        sd_n = 1'b0;
        tick(4);
        sd_n = 1'b1;
        wait_st(MCS_EXT, 1200);
        watch(300);
        chk("loop_sync", ts > 0, 1'b1);
        chk("loop_rate", ts >= 14 && ts <= 16, 1'b1);
        chk("loop_held", state, MCS_EXT);
        chk("loop_mod", tm > 0, 1'b1);
    endtask
    initial begin
        tick(20000);
        fails++;
        final_report();
    end
    initial begin
        tick(10);
        rst = 1'b0;
        t_shut();
        t_static();
        t_ext();
        t_loop();
        final_report();
    end
endmodule
